// ---- src/sarseq_pkg.sv ----
package sarseq_pkg;

  // ---------------------------------------------------------------
  // Conversion geometry
  // ---------------------------------------------------------------
  localparam int unsigned RES_BITS      = 14;
  localparam int unsigned SLOW_TRIALS   = 8;
  localparam int unsigned FAST_TRIALS   = 6;
  localparam int unsigned SHORT_CYCLE   = 15;

  // ---------------------------------------------------------------
  // Trial pacing, counted in mclk cycles
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SLOW_STEP_NS  = 400;
  localparam int unsigned FAST_STEP_NS  = 120;
  localparam int unsigned SLOW_STEP_CYC = (SLOW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAST_STEP_CYC = (FAST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [13:0] SAR_RESET     = 14'h0000;

  typedef enum logic [2:0] {
    SARSEQ_IDLE  = 3'b001,
    SARSEQ_TRIAL = 3'b010,
    SARSEQ_HALT  = 3'b100
  } sarseq_state_t;

endpackage : sarseq_pkg

// ---- src/sarseq_pacer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Settling timer: strobes once per trial, slow or fast length chosen per trial.
module sarseq_pacer #(
  parameter int unsigned SLOW_CYC = sarseq_pkg::SLOW_STEP_CYC,
  parameter int unsigned FAST_CYC = sarseq_pkg::FAST_STEP_CYC
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic clkEn,
  input  wire logic run,
  input  wire logic slowSel,
  output logic      stepDone
);
  localparam int unsigned CW = $clog2(SLOW_CYC + 1);

  initial begin
    if (SLOW_CYC < 1 || FAST_CYC < 1 || FAST_CYC > SLOW_CYC) begin
      $error("sarseq_pacer: bad step lengths");
    end
  end

  logic [CW-1:0] count_reg;
  logic [CW-1:0] limit;

  assign limit    = slowSel ? CW'(SLOW_CYC - 1) : CW'(FAST_CYC - 1);
  assign stepDone = run && (count_reg >= limit);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else if (clkEn) begin
      if (!run || stepDone) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + CW'(1);
      end
    end
  end

endmodule : sarseq_pacer

`default_nettype wire

// ---- src/sar_conversion_sequencer.sv ----
// Functional notes
// - A 14-bit approximation register drives the DAC trial code.
// - First 8 trials step slower than the last 6 trials.
// - Conversion ends after 14 trials, or earlier at a chosen end position.
// - With hold/run low, a new conversion starts after each one completes.
// - With hold/run high at completion, halt and keep the result.
// - A low-going pulse on hold/run restarts a halted sequencer.
// - Status is high exactly while a conversion is in progress.
// - Status falls when a new result is valid on the result output.
// - Bipolar codes are two's complement; the top bit is weighted opposite.
`timescale 1ns/1ps
`default_nettype none

module sar_conversion_sequencer #(
  parameter int unsigned RES      = sarseq_pkg::RES_BITS,
  parameter int unsigned SLOW_N   = sarseq_pkg::SLOW_TRIALS,
  parameter int unsigned SLOW_CYC = sarseq_pkg::SLOW_STEP_CYC,
  parameter int unsigned FAST_CYC = sarseq_pkg::FAST_STEP_CYC
) (
  input  wire logic           mclk,
  input  wire logic           nrst,
  input  wire logic           clkEn,
  input  wire logic           holdRun,
  input  wire logic           compHigh,
  input  wire logic [3:0]     endPos,
  input  wire logic           bipolar,
  output logic     [RES-1:0]  trialCode,
  output logic                dacTopCodeBit,
  output logic     [RES-1:0]  result,
  output logic                status
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Trial index and end position are 4-bit, so resolution is fixed here
  initial begin
    if (RES != 14 || SLOW_N >= RES) begin
      $error("sar_conversion_sequencer: unsupported resolution");
    end
    if (SLOW_CYC < 1 || FAST_CYC < 1) begin
      $error("sar_conversion_sequencer: unsupported step lengths");
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sarseq_pkg::sarseq_state_t state_reg;
  logic [RES-1:0] sar_reg;
  logic [RES-1:0] mask_reg;
  logic [RES-1:0] result_reg;
  logic [3:0]     trialIdx_reg;
  sarseq_pkg::sarseq_state_t state_next;
  logic [RES-1:0] sar_next;
  logic [RES-1:0] mask_next;
  logic [3:0]     trialIdx_next;
  logic [RES-1:0] resolved;
  logic           holdPrev_reg;
  logic           stepDone;
  logic           lastTrial;
  logic [3:0]     endTrials;
  logic           keepBit;
  logic           restartPulse;

  // End position is counted in bits like the short-cycle tap: 15 means 14 trials
  assign endTrials = (endPos < 4'd2 || endPos > 4'(sarseq_pkg::SHORT_CYCLE))
                     ? 4'(RES) : endPos - 4'd1;
  assign lastTrial = (trialIdx_reg + 4'd1 >= endTrials);

  // Comparator high means the trial overshot. For the top bit in bipolar
  // mode its weight is reversed, so the sense of the decision flips.
  assign keepBit = (bipolar && mask_reg[RES-1]) ? compHigh : !compHigh;

  // Code with the bit under test decided, before the next bit is tried
  assign resolved = keepBit ? sar_reg : (sar_reg & ~mask_reg);

  // Rising edge that ends a low pulse; HALT already restarts on the first cycle hold/run is low
  assign restartPulse = holdRun && !holdPrev_reg;

  sarseq_pacer #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_pacer (
    .mclk     (mclk),
    .nrst     (nrst),
    .clkEn    (clkEn),
    .run      (state_reg == sarseq_pkg::SARSEQ_TRIAL),
    .slowSel  (trialIdx_reg < 4'(SLOW_N)),
    .stepDone (stepDone)
  );

  // ---------------------------------------------------------------
  // Hold/run edge tracking
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      holdPrev_reg <= 1'b1;
    end else if (clkEn) begin
      holdPrev_reg <= holdRun;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer next-value decode
  // ---------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    sar_next      = sar_reg;
    mask_next     = mask_reg;
    trialIdx_next = trialIdx_reg;
    unique case (state_reg)
      sarseq_pkg::SARSEQ_IDLE: begin
        sar_next      = {1'b1, {(RES-1){1'b0}}};
        mask_next     = {1'b1, {(RES-1){1'b0}}};
        trialIdx_next = 4'd0;
        state_next    = sarseq_pkg::SARSEQ_TRIAL;
      end
      sarseq_pkg::SARSEQ_TRIAL: begin
        if (stepDone) begin
          // Keep or drop this bit, then try the next lower one
          sar_next      = resolved | (lastTrial ? '0 : (mask_reg >> 1));
          mask_next     = mask_reg >> 1;
          trialIdx_next = trialIdx_reg + 4'd1;
          if (lastTrial) begin
            if (holdRun) begin
              state_next = sarseq_pkg::SARSEQ_HALT;
            end else begin
              state_next = sarseq_pkg::SARSEQ_IDLE;
            end
          end
        end
      end
      sarseq_pkg::SARSEQ_HALT: begin
        if (!holdRun || restartPulse) begin
          state_next = sarseq_pkg::SARSEQ_IDLE;
        end
      end
      default: begin
        // Upset codes fall back to a fresh conversion
        state_next = sarseq_pkg::SARSEQ_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= sarseq_pkg::SARSEQ_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Approximation register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sar_reg <= sarseq_pkg::SAR_RESET;
    end else if (clkEn) begin
      sar_reg <= sar_next;
    end
  end

  // ---------------------------------------------------------------
  // Bit-under-test mask
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= '0;
    end else if (clkEn) begin
      mask_reg <= mask_next;
    end
  end

  // ---------------------------------------------------------------
  // Trial counter
  // ---------------------------------------------------------------
  // Picks slow or fast pacing, so it must restart with every conversion
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      trialIdx_reg <= 4'd0;
    end else if (clkEn) begin
      trialIdx_reg <= trialIdx_next;
    end
  end

  // ---------------------------------------------------------------
  // Result capture
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      result_reg <= '0;
    end else if (clkEn && state_reg == sarseq_pkg::SARSEQ_TRIAL && stepDone && lastTrial) begin
      // Untested low bits stay zero on a short-cycled conversion
      result_reg <= resolved;
    end
  end

  assign trialCode     = sar_reg;
  assign dacTopCodeBit = sar_reg[RES-1];
  assign result        = result_reg;
  // Status drops in the same cycle the result register is loaded
  assign status        = (state_reg == sarseq_pkg::SARSEQ_TRIAL);

endmodule : sar_conversion_sequencer

`default_nettype wire

// ---- sim/sarseq_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module sarseq_properties #(
  parameter int SLOW_CYC = 2,
  parameter int FAST_CYC = 1
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        clkEn,
  input wire logic        holdRun,
  input wire logic        compHigh,
  input wire logic [3:0]  endPos,
  input wire logic        bipolar,
  input wire logic [13:0] trialCode,
  input wire logic        dacTopCodeBit,
  input wire logic [13:0] result,
  input wire logic        status
);
  // ----
  // Checks
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  int busy;
  int nt;
  assign nt = (endPos < 4'h2) ? 14 : int'(endPos) - 1;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) busy <= 0;
    else if (!status) busy <= 0;
    else if (clkEn) busy <= busy + 1;
  end
  a_top_mirror: assert property (dacTopCodeBit == trialCode[13]) else $error("top bit");
  a_first_trial: assert property ($rose(status) |-> trialCode == 14'h2000) else $error("first");
  a_result_held: assert property (status |-> $stable(result)) else $error("result moved");
  a_conv_length: assert property ($fell(status) |-> busy == ((nt > 8) ?
    8 * SLOW_CYC + (nt - 8) * FAST_CYC : nt * SLOW_CYC)) else $error("length");
  a_free_run: assert property ($fell(status) && !$past(holdRun) && clkEn |=> status)
    else $error("no rerun");
  a_halt_keep: assert property ($fell(status) && $past(holdRun) && holdRun |=> !status [*2])
    else $error("no halt");
  a_restart: assert property ($fell(holdRun) && !status |-> ##[1:6] status)
    else $error("no restart");
  a_one_step: assert property (status && $past(status) && $changed(trialCode) |->
    $countones(trialCode ^ $past(trialCode)) inside {[1:2]}) else $error("step");
endmodule : sarseq_properties

bind sar_conversion_sequencer sarseq_properties #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_p (
  .mclk(mclk), .nrst(nrst), .clkEn(clkEn), .holdRun(holdRun), .compHigh(compHigh),
  .endPos(endPos), .bipolar(bipolar), .trialCode(trialCode), .dacTopCodeBit(dacTopCodeBit),
  .result(result), .status(status));
`default_nettype wire

// ---- sim/sarseq_comparator.sv ----
`timescale 1ns/1ps
`default_nettype none
module sarseq_comparator (
  input  wire logic [13:0] trialCode,
  input  wire logic        bipolar,
  input  wire logic [13:0] target,
  output logic             compHigh
);
  // Sign trial follows the target's sign; lower bits then order as plain binary
  assign compHigh = (bipolar && trialCode == 14'h2000) ? target[13] : (trialCode > target);
endmodule : sarseq_comparator
`default_nettype wire

// ---- sim/sar_conversion_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_test;
  logic        mclk, nrst, clkEn, holdRun, compHigh, bipolar, dacTopCodeBit, status;
  logic [3:0]  endPos;
  logic [13:0] trialCode, result, target;
  int          n_errors, num_checks;
  sar_conversion_sequencer #(.SLOW_CYC(2), .FAST_CYC(1)) u_dut (.mclk(mclk), .nrst(nrst),
    .clkEn(clkEn), .holdRun(holdRun), .compHigh(compHigh), .endPos(endPos), .bipolar(bipolar),
    .trialCode(trialCode), .dacTopCodeBit(dacTopCodeBit), .result(result), .status(status));
  sarseq_comparator u_cmp (.trialCode(trialCode), .bipolar(bipolar), .target(target),
    .compHigh(compHigh));
  // ----
  // Tasks
  // ----
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic wait_st(input logic v);
    for (int i = 0; i < 200 && status !== v; i++) @(negedge mclk);
    check({13'h0, status}, {13'h0, v});
  endtask : wait_st
  task automatic t_single;
    logic [13:0] tg [7] = '{14'h3fff, 14'h0, 14'h1555, 14'h2abc, 14'h1234, 14'h2abc, 14'h3fff};
    logic [13:0] ex [7] = '{14'h3fff, 14'h0, 14'h1555, 14'h2abc, 14'h1234, 14'h2a80, 14'h2000};
    logic [3:0]  ps [7] = '{4'hf, 4'hf, 4'h0, 4'hf, 4'hf, 4'h9, 4'h2};
    for (int i = 0; i < 7; i++) begin
      target = tg[i];
      bipolar = (i == 3 || i == 4);
      endPos = ps[i];
      holdRun = 1'b0;
      repeat (2) @(negedge mclk);
      holdRun = 1'b1;
      wait_st(1'b1);
      wait_st(1'b0);
      check(result, ex[i]);
      repeat (4) @(negedge mclk);
      check({13'h0, status}, 14'h0);
      check(result, ex[i]);
    end
  endtask : t_single
  task automatic t_free_run;
    target = 14'h0f0f;
    bipolar = 1'b0;
    endPos = 4'hf;
    holdRun = 1'b0;
    for (int i = 0; i < 3; i++) begin
      wait_st(1'b1);
      wait_st(1'b0);
      check(result, target);
      @(negedge mclk);
      check({13'h0, status}, 14'h1);
    end
    holdRun = 1'b1;
    wait_st(1'b0);
  endtask : t_free_run
  // A frozen sequencer must hold its trial code and status mid-conversion
  task automatic t_freeze;
    logic [13:0] code;
    target = 14'h0a5a;
    bipolar = 1'b0;
    endPos = 4'hf;
    holdRun = 1'b0;
    repeat (2) @(negedge mclk);
    holdRun = 1'b1;
    wait_st(1'b1);
    check({13'h0, dacTopCodeBit}, 14'h1);
    repeat (6) @(negedge mclk);
    clkEn = 1'b0;
    code = trialCode;
    repeat (10) @(negedge mclk);
    check(trialCode, code);
    check({13'h0, status}, 14'h1);
    clkEn = 1'b1;
    wait_st(1'b0);
    check(result, target);
    check({13'h0, dacTopCodeBit}, 14'h0);
  endtask : t_freeze
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    results();
  end
  initial begin
    n_errors = 0;
    num_checks = 0;
    nrst = 1'b0;
    clkEn = 1'b1;
    holdRun = 1'b1;
    bipolar = 1'b0;
    endPos = 4'hf;
    target = 14'h0;
    repeat (8) @(negedge mclk);
    check(trialCode, 14'h0);
    nrst = 1'b1;
    wait_st(1'b1);
    check(trialCode, 14'h2000);
    wait_st(1'b0);
    t_single();
    t_free_run();
    t_freeze();
    results();
  end
endmodule : sar_conversion_sequencer_test
`default_nettype wire
